//--- rtl/rtcc_calendar.sv
`timescale 1ns/1ns
`default_nettype none

module rtcc_calendar
(
    // Clock and resets.
    input  wire logic       i_sys_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_rtc_nrst,
    // Carry from the minute counter and its busy flag.
    input  wire logic       i_hour_tick,
    input  wire logic       i_busy,
    // Byte register port.
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // Calendar state.
    logic [4:0]  hour_count;
    logic        hour_format_select;
    logic        half_day_flag;
    logic [6:0]  year_count;
    logic [3:0]  month_count;
    logic [2:0]  weekday_value;
    logic [4:0]  day_of_month_count;
    logic [31:0] scratch;
    logic [4:0]  next_hour_count;
    logic        next_hour_format_select;
    logic        next_half_day_flag;
    logic [6:0]  next_year_count;
    logic [3:0]  next_month_count;
    logic [2:0]  next_weekday_value;
    logic [4:0]  next_day_of_month_count;
    logic [31:0] next_scratch;
    logic [7:0]  next_reg_rdata;
    logic        day_roll;
    logic        time_wr;
    logic [4:0]  days_in_month;

    rtcc_month_if mif ();

    assign mif.month_count = month_count;
    assign mif.year_count  = year_count;
    assign days_in_month   = mif.days_in_month;

    rtcc_month_len u_month_len
    (
        .mif (mif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Time writes are dropped while busy so a half-applied update cannot tear.
    assign time_wr = i_reg_wr && !i_busy && (i_reg_addr >= rtcc_pkg::OFS_HOUR)
                     && (i_reg_addr <= rtcc_pkg::OFS_WKDATE);

    // Next calendar values: counting first, then a host write overrides its register.
    always_comb
    begin
        next_hour_count         = hour_count;
        next_hour_format_select = hour_format_select;
        next_half_day_flag      = half_day_flag;
        next_year_count         = year_count;
        next_month_count        = month_count;
        next_weekday_value      = weekday_value;
        next_day_of_month_count = day_of_month_count;
        next_scratch            = scratch;
        day_roll                = 1'b0;
        if (i_hour_tick)
        begin
            if (!hour_format_select)
            begin
                if (hour_count >= rtcc_pkg::HOUR_MAX_24)
                begin
                    next_hour_count = 5'h00;
                    day_roll        = 1'b1;
                end
                else
                begin
                    next_hour_count = hour_count + 5'h01;
                end
            end
            else if (hour_count >= rtcc_pkg::HOUR_NOON)
            begin
                next_hour_count = rtcc_pkg::HOUR_ONE;
            end
            else if (hour_count == rtcc_pkg::HOUR_ELEVEN)
            begin
                next_hour_count    = rtcc_pkg::HOUR_NOON;
                next_half_day_flag = !half_day_flag;
                day_roll           = half_day_flag;
            end
            else
            begin
                next_hour_count = hour_count + 5'h01;
            end
        end
        if (day_roll)
        begin
            // Weekday just steps; it is never checked against the date.
            next_weekday_value = (weekday_value >= rtcc_pkg::WEEKDAY_MAX) ?
                                 rtcc_pkg::WEEKDAY_MON : weekday_value + 3'h1;
            if (day_of_month_count >= days_in_month)
            begin
                next_day_of_month_count = rtcc_pkg::DAY_FIRST;
                if (month_count >= rtcc_pkg::MONTH_MAX)
                begin
                    next_month_count = 4'h1;
                    next_year_count  = (year_count >= rtcc_pkg::YEAR_MAX) ?
                                       7'h00 : year_count + 7'h01;
                end
                else
                begin
                    next_month_count = month_count + 4'h1;
                end
            end
            else
            begin
                next_day_of_month_count = day_of_month_count + 5'h01;
            end
        end
        if (time_wr)
        begin
            case (i_reg_addr)
                rtcc_pkg::OFS_HOUR:
                begin
                    next_hour_format_select = i_reg_wdata[rtcc_pkg::HOUR_FMT_BIT];
                    next_half_day_flag      = i_reg_wdata[rtcc_pkg::HALF_DAY_BIT];
                    next_hour_count         = i_reg_wdata[4:0];
                end
                rtcc_pkg::OFS_YEAR:   next_year_count  = i_reg_wdata[6:0];
                rtcc_pkg::OFS_MONTH:  next_month_count = i_reg_wdata[3:0];
                rtcc_pkg::OFS_WKDATE:
                begin
                    next_weekday_value      = i_reg_wdata[7:5];
                    next_day_of_month_count = i_reg_wdata[4:0];
                end
                default: ;
            endcase
        end
        // Scratch bytes are free storage and ignore the busy flag.
        if (i_reg_wr && (i_reg_addr >= rtcc_pkg::OFS_USER0)
            && (i_reg_addr <= rtcc_pkg::OFS_USER3))
        begin
            case (i_reg_addr[1:0])
                2'h0:    next_scratch[7:0]   = i_reg_wdata;
                2'h1:    next_scratch[15:8]  = i_reg_wdata;
                2'h2:    next_scratch[23:16] = i_reg_wdata;
                default: next_scratch[31:24] = i_reg_wdata;
            endcase
        end
    end

    // Only the clock reset clears the calendar; the general reset leaves it running.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rtc_nrst)
        begin
            hour_count         <= rtcc_pkg::RST_HOUR[4:0];
            hour_format_select <= rtcc_pkg::RST_HOUR[rtcc_pkg::HOUR_FMT_BIT];
            half_day_flag      <= rtcc_pkg::RST_HOUR[rtcc_pkg::HALF_DAY_BIT];
            year_count         <= rtcc_pkg::RST_YEAR[6:0];
            month_count        <= rtcc_pkg::RST_MONTH[3:0];
            weekday_value      <= rtcc_pkg::RST_WKDATE[7:5];
            day_of_month_count <= rtcc_pkg::RST_WKDATE[4:0];
            scratch            <= {4{rtcc_pkg::RST_USER}};
        end
        else
        begin
            hour_count         <= next_hour_count;
            hour_format_select <= next_hour_format_select;
            half_day_flag      <= next_half_day_flag;
            year_count         <= next_year_count;
            month_count        <= next_month_count;
            weekday_value      <= next_weekday_value;
            day_of_month_count <= next_day_of_month_count;
            scratch            <= next_scratch;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data; reserved bits read as zero, unmapped offsets read as zero.
    always_comb
    begin
        case (i_reg_addr)
            rtcc_pkg::OFS_HOUR:   next_reg_rdata = {hour_format_select, half_day_flag,
                                                    1'b0, hour_count};
            rtcc_pkg::OFS_YEAR:   next_reg_rdata = {1'b0, year_count};
            rtcc_pkg::OFS_MONTH:  next_reg_rdata = {4'h0, month_count};
            rtcc_pkg::OFS_WKDATE: next_reg_rdata = {weekday_value, day_of_month_count};
            rtcc_pkg::OFS_USER0:  next_reg_rdata = scratch[7:0];
            rtcc_pkg::OFS_USER1:  next_reg_rdata = scratch[15:8];
            rtcc_pkg::OFS_USER2:  next_reg_rdata = scratch[23:16];
            rtcc_pkg::OFS_USER3:  next_reg_rdata = scratch[31:24];
            default:              next_reg_rdata = 8'h00;
        endcase
    end

    // The read register is bus state, so the general reset may clear it.
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_nrst)
        begin
            o_reg_rdata <= 8'h00;
        end
        else
        begin
            o_reg_rdata <= next_reg_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    hour_wrap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rtc_nrst)
        (i_hour_tick && !hour_format_select && hour_count == 5'h17 && !i_reg_wr)
        |=> (hour_count == 5'h00) && (day_of_month_count != $past(day_of_month_count)))
        else $error("24-hour count did not wrap to zero with a day step");

    half_day_a: assert property (@(posedge i_sys_clk) disable iff (!i_rtc_nrst)
        (i_hour_tick && hour_format_select && hour_count == 5'h0B && !i_reg_wr)
        |=> (hour_count == 5'h0C) && (half_day_flag != $past(half_day_flag)))
        else $error("12-hour count did not flip the half-day flag at twelve");

    year_wrap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rtc_nrst)
        (day_roll && month_count == 4'hC && day_of_month_count >= days_in_month
         && year_count == 7'h3F && !i_reg_wr) |=> (year_count == 7'h00))
        else $error("Year did not wrap after 63");

    month_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_rtc_nrst)
        (day_roll && month_count < 4'hC && day_of_month_count >= days_in_month
         && !i_reg_wr) |=> (month_count == $past(month_count) + 4'h1)
         && (day_of_month_count == 5'h01))
        else $error("Month did not advance at end of month");

    weekday_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rtc_nrst)
        (!day_roll && !time_wr) |=> $stable(weekday_value))
        else $error("Weekday changed without a day step or write");

    scratch_iso_a: assert property (@(posedge i_sys_clk) disable iff (!i_rtc_nrst)
        (i_reg_wr && i_reg_addr == 8'h18 && !i_hour_tick)
        |=> $stable(hour_count) && (scratch[7:0] == $past(i_reg_wdata)))
        else $error("Scratch write misbehaved");

    leap_feb_a: assert property (@(posedge i_sys_clk) disable iff (!i_rtc_nrst)
        (month_count == 4'h2) |-> (days_in_month == ((year_count[1:0] == 2'h0) ? 5'h1D : 5'h1C)))
        else $error("February length wrong");

    busy_block_a: assert property (@(posedge i_sys_clk) disable iff (!i_rtc_nrst)
        (i_busy && i_reg_wr && i_reg_addr == 8'h15 && !day_roll) |=> $stable(year_count))
        else $error("Year written while busy");

    rtc_reset_a: assert property (@(posedge i_sys_clk)
        (!i_rtc_nrst) |=> (day_of_month_count == 5'h01) && (weekday_value == 3'h6)
        && (year_count == 7'h0D) && (month_count == 4'h1))
        else $error("Clock reset values wrong");

endmodule // rtcc_calendar

`default_nettype wire

//--- rtl/rtcc_month_if.sv
`timescale 1ns/1ns
`default_nettype none

// Carries the month and year to the month length lookup and its answer back.
interface rtcc_month_if;
    logic [3:0] month_count;
    logic [6:0] year_count;
    logic [4:0] days_in_month;
    modport asker (output month_count, output year_count, input days_in_month);
    modport teller (input month_count, input year_count, output days_in_month);
endinterface

`default_nettype wire

//--- rtl/rtcc_month_len.sv
`timescale 1ns/1ns
`default_nettype none

module rtcc_month_len
(
    // Month and year in, length out.
    rtcc_month_if.teller mif
);

    ////////////////////////////////////////////////////////////////////////////
    // Every fourth year is a leap year; the range 2000 to 2063 needs no century rule.
    always_comb
    begin
        case (mif.month_count)
            4'h4, 4'h6, 4'h9, 4'hB: mif.days_in_month = 5'h1E;
            rtcc_pkg::MONTH_FEB:   mif.days_in_month =
                (mif.year_count[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            default:               mif.days_in_month = 5'h1F;
        endcase
    end

endmodule // rtcc_month_len

`default_nettype wire

//--- rtl/rtcc_pkg.sv
`default_nettype none

package rtcc_pkg;

    // Register offsets on the byte-wide register port.
    localparam logic [7:0] OFS_HOUR    = 8'h14;
    localparam logic [7:0] OFS_YEAR    = 8'h15;
    localparam logic [7:0] OFS_MONTH   = 8'h16;
    localparam logic [7:0] OFS_WKDATE  = 8'h17;
    localparam logic [7:0] OFS_USER0   = 8'h18;
    localparam logic [7:0] OFS_USER1   = 8'h19;
    localparam logic [7:0] OFS_USER2   = 8'h1A;
    localparam logic [7:0] OFS_USER3   = 8'h1B;

    // Field positions.
    localparam int HOUR_FMT_BIT  = 7;
    localparam int HALF_DAY_BIT  = 6;
    localparam int WEEKDAY_LSB   = 5;

    // Values after the clock reset.
    localparam logic [7:0] RST_HOUR    = 8'h00;
    localparam logic [7:0] RST_YEAR    = 8'h0D;
    localparam logic [7:0] RST_MONTH   = 8'h01;
    localparam logic [7:0] RST_WKDATE  = 8'hC1;
    localparam logic [7:0] RST_USER    = 8'h00;

    // Counting limits.
    localparam logic [4:0] HOUR_MAX_24 = 5'h17;
    localparam logic [4:0] HOUR_NOON   = 5'h0C;
    localparam logic [4:0] HOUR_ELEVEN = 5'h0B;
    localparam logic [4:0] HOUR_ONE    = 5'h01;
    localparam logic [6:0] YEAR_MAX    = 7'h3F;
    localparam logic [3:0] MONTH_MAX   = 4'hC;
    localparam logic [3:0] MONTH_FEB   = 4'h2;
    localparam logic [2:0] WEEKDAY_MAX = 3'h7;
    localparam logic [2:0] WEEKDAY_MON = 3'h1;
    localparam logic [4:0] DAY_FIRST   = 5'h01;

endpackage

`default_nettype wire

//--- verification/rtcc_calendar_tb.sv
`timescale 1ns/1ns
`default_nettype none

module rtcc_calendar_tb;
    logic       clk;
    logic       nrst;
    logic       rtc_nrst;
    logic [7:0] rdata;
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
    logic       tick;
    logic       busy;
    logic [7:0] rd;
    int         num_errors;
    int         samples_checked;
    int         cycles;

    rtcc_calendar DUT (.i_sys_clk(clk), .i_nrst(nrst), .i_rtc_nrst(rtc_nrst),
        .i_hour_tick(tick), .i_busy(busy), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata));

    rtcc_host_model host (.i_sys_clk(clk), .i_reg_rdata(rdata), .o_reg_addr(addr),
        .o_reg_wr(wr), .o_reg_wdata(wdata), .o_hour_tick(tick), .o_busy(busy));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling well above the roughly 150 cycles the run needs.
    always #10 clk = ~clk;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Checks made %0d, mismatches %0d.", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Reads one register and compares it against the expected byte.
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        host.rd_reg(a, rd);
        samples_checked++;
        if (rd !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, rd);
            num_errors++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Values after the clock reset.
    task automatic t_reset_values();
        rdchk("hour", 8'h14, 8'h00);
        rdchk("year", 8'h15, 8'h0D);
        rdchk("month", 8'h16, 8'h01);
        rdchk("wkdate", 8'h17, 8'hC1);
        for (int i = 0; i < 4; i++)
            rdchk("scratch", 8'h18 + 8'(i), 8'h00);
    endtask

    // General reset keeps state; only the clock reset clears it.
    task automatic t_resets();
        host.wr_reg(8'h18, 8'h5A);
        host.wr_reg(8'h14, 8'h13);
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        nrst = 1'b1;
        rdchk("scratch kept", 8'h18, 8'h5A);
        rdchk("hour kept", 8'h14, 8'h13);
        rtc_nrst = 1'b0;
        @(posedge clk);
        #1;
        rtc_nrst = 1'b1;
        rdchk("scratch cleared", 8'h18, 8'h00);
        rdchk("hour cleared", 8'h14, 8'h00);
    endtask

    // Scratch bytes, an unmapped place and reserved month bits.
    task automatic t_scratch();
        for (int i = 0; i < 4; i++)
            host.wr_reg(8'h18 + 8'(i), 8'hA5 ^ 8'(i));
        for (int i = 0; i < 4; i++)
            rdchk("scratch rw", 8'h18 + 8'(i), 8'hA5 ^ 8'(i));
        rdchk("hour untouched", 8'h14, 8'h00);
        host.wr_reg(8'h1C, 8'h33);
        rdchk("unmapped", 8'h1C, 8'h00);
        host.wr_reg(8'h16, 8'hF3);
        rdchk("month reserved", 8'h16, 8'h03);
    endtask

    // Time writes refused while busy, scratch still taken.
    task automatic t_busy();
        host.o_busy = 1'b1;
        host.wr_reg(8'h14, 8'h05);
        host.wr_reg(8'h15, 8'h2A);
        host.wr_reg(8'h1B, 8'h77);
        rdchk("hour busy", 8'h14, 8'h00);
        rdchk("year busy", 8'h15, 8'h0D);
        rdchk("scratch busy", 8'h1B, 8'h77);
        host.o_busy = 1'b0;
        host.wr_reg(8'h14, 8'h05);
        rdchk("hour free", 8'h14, 8'h05);
    endtask

    // Sets a date at 23 h, lets one hour pass and checks the new date.
    task automatic roll(input logic [7:0] y, input logic [7:0] m, input logic [7:0] wd,
                        input logic [7:0] ye, input logic [7:0] me, input logic [7:0] wde);
        host.wr_reg(8'h15, y);
        host.wr_reg(8'h16, m);
        host.wr_reg(8'h17, wd);
        host.wr_reg(8'h14, 8'h17);
        host.tick();
        rdchk("hour wrap", 8'h14, 8'h00);
        rdchk("year", 8'h15, ye);
        rdchk("month", 8'h16, me);
        rdchk("wkdate", 8'h17, wde);
    endtask

    // Month ends, leap February and the last supported year.
    task automatic t_calendar();
        roll(8'h00, 8'h01, 8'hFF, 8'h00, 8'h02, 8'h21);
        roll(8'h04, 8'h02, 8'h5C, 8'h04, 8'h02, 8'h7D);
        roll(8'h04, 8'h02, 8'h7D, 8'h04, 8'h03, 8'h81);
        roll(8'h05, 8'h02, 8'h5C, 8'h05, 8'h03, 8'h61);
        roll(8'h05, 8'h04, 8'h3E, 8'h05, 8'h05, 8'h41);
        roll(8'h3F, 8'h0C, 8'hDF, 8'h00, 8'h01, 8'hE1);
    endtask

    // Twelve-hour counting: 11 to 12 flips the flag, 12 to 1, PM to AM steps the day.
    task automatic t_twelve();
        host.wr_reg(8'h14, 8'h8B);
        host.tick();
        rdchk("am to pm", 8'h14, 8'hCC);
        host.tick();
        rdchk("twelve to one", 8'h14, 8'hC1);
        host.wr_reg(8'h17, 8'h2A);
        host.wr_reg(8'h14, 8'hCB);
        host.tick();
        rdchk("pm to am", 8'h14, 8'h8C);
        rdchk("day step", 8'h17, 8'h4B);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: both resets held for two cycles, then the scenarios.
    initial
    begin
        clk             = 1'b0;
        nrst            = 1'b0;
        rtc_nrst        = 1'b0;
        num_errors      = 0;
        samples_checked = 0;
        cycles          = 0;
        repeat (2) @(posedge clk);
        #1;
        nrst     = 1'b1;
        rtc_nrst = 1'b1;
        t_reset_values();
        t_resets();
        t_scratch();
        t_busy();
        t_calendar();
        t_twelve();
        end_of_test();
    end
endmodule // rtcc_calendar_tb

`default_nettype wire

//--- verification/rtcc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module rtcc_host_model
(
    // Clock and read data.
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_reg_rdata,
    // Register port and minute-carry side.
    output logic      [7:0] o_reg_addr,
    output logic            o_reg_wr,
    output logic      [7:0] o_reg_wdata,
    output logic            o_hour_tick,
    output logic            o_busy
);
    // Idle values at time zero.
    initial
    begin
        o_reg_addr  = 8'h00;
        o_reg_wr    = 1'b0;
        o_reg_wdata = 8'h00;
        o_hour_tick = 1'b0;
        o_busy      = 1'b0;
    end

    // One strobe per byte; idle data is inverted so a stale byte is never trusted.
    // An idle edge follows each strobe, so back-to-back writes never re-raise it
    // in the same time step in which it was lowered.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        o_reg_addr  = a;
        o_reg_wr    = 1'b1;
        o_reg_wdata = d;
        @(posedge i_sys_clk);
        #1;
        o_reg_wr    = 1'b0;
        o_reg_wdata = ~d;
        @(posedge i_sys_clk);
        #1;
    endtask

    // Read data is registered, so it is taken one edge after the address.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        o_reg_addr = a;
        @(posedge i_sys_clk);
        #1;
        d = i_reg_rdata;
    endtask

    // One-cycle carry from the minute counter.
    task automatic tick();
        o_hour_tick = 1'b1;
        @(posedge i_sys_clk);
        #1;
        o_hour_tick = 1'b0;
    endtask
endmodule // rtcc_host_model

`default_nettype wire
